// [core/cca_top.sv]
// Operation
// (RULE_01) 8-bit input takes one cycle, 16-bit two, 32-bit four.
// (RULE_02) Width codes 00,01,10,11 select 8,16,24,32 bit input.
// (RULE_03) Ordering bit mirrors data across the width before the engine.
// (RULE_04) Seeds and results keep data bit 31 as most significant.
// (RULE_05) Checksum adds previous carry unless carry discard is set.
// (RULE_06) With seed bit set, an entry loads the seed, not data.
// (RULE_07) Algorithm field: off, two checksums, three fixed-polynomial CRCs, reserved.
// (RULE_08) Code 111 clears state, restores default seeds, keeps algorithm.
// (RULE_09) Config busy bit reads one while a result is being computed.
// (RULE_10) Software need not poll busy between entries or before reads; a landing result overwrites high bytes written while busy.
// (RULE_11) Writing the lowest data byte starts calculation; higher bytes just store.
// (RULE_12) Software writes high bytes first; 8-bit width uses lowest byte only.
// (RULE_13) Four data byte registers are input and result port, low first.
// (RULE_14) Config reads back fields as written, busy replaces algorithm field.
// (RULE_15) Each calculation leaves the running result in the data registers.
`timescale 1ns/100ps
`include "cca_params.svh"

////////////////////////////////////////////////////////////////////////////////
module cca_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module cca_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr
);
   localparam int EW = $bits(cca_pkg::cca_entry_t);

   cca_pkg::cca_cfg_t   cfg_ff;
   cca_pkg::cca_alg_t   alg_ff;
   cca_pkg::cca_state_t state_ff;
   cca_pkg::cca_entry_t push_entry;
   cca_pkg::cca_entry_t pop_entry;
   logic [31:0] data_ff;
   logic [31:0] acc_ff;
   logic        carry_ff;
   logic [31:0] ew_ff;
   logic [1:0]  left_ff;
   logic        hi_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        sel_cfg;
   logic        sel_d0;
   logic        sel_d1;
   logic        sel_d2;
   logic        sel_d3;
   logic        mapped;
   logic        done;
   logic        wr_done;
   logic        enabled;
   logic        push_valid;
   logic        push_ready;
   logic        pop_valid;
   logic        pop_ready;
   logic        clear_cmd;
   logic        busy;
   logic [31:0] mir8;
   logic [31:0] mir16;
   logic [31:0] mir24;
   logic [31:0] mir32;
   logic [31:0] engine_input_word;
   logic [31:0] nxt_acc;
   logic        nxt_carry;
   logic [31:0] dflt_seed;
   logic [7:0]  cfg_rd;

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   // (RULE_13) Byte data registers
   assign sel_cfg = (paddr == {`CCA_IDX_CFG, 2'b00});
   assign sel_d0  = (paddr == {`CCA_IDX_DATA0, 2'b00});
   assign sel_d1  = (paddr == {`CCA_IDX_DATA1, 2'b00});
   assign sel_d2  = (paddr == {`CCA_IDX_DATA2, 2'b00});
   assign sel_d3  = (paddr == {`CCA_IDX_DATA3, 2'b00});
   assign mapped  = sel_cfg | sel_d0 | sel_d1 | sel_d2 | sel_d3;
   assign done    = psel & penable & pready_ff;
   assign wr_done = done & pwrite & mapped;
   assign enabled = (alg_ff != cca_pkg::CCA_ALG_OFF) && (alg_ff != cca_pkg::CCA_ALG_RSVD);
   assign clear_cmd = wr_done & sel_cfg & (pwdata[2:0] == 3'h7);
   assign busy    = pop_valid | (state_ff == cca_pkg::CCA_ST_RUN);

   // (RULE_14) Busy replaces the write-only algorithm field
   assign cfg_rd = {cfg_ff.input_width_sel, cfg_ff.rev, cfg_ff.carry_discard, cfg_ff.seed,
                    2'b00, busy};

   ////////////////////////////////////////////////////////////////////////////
   // APB answer; a low-byte write waits while the FIFO is full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         // (RULE_10) Data reads wait, so software never polls busy
         pready_ff  <= psel & ~pready_ff & ~(pwrite & sel_d0 & enabled & ~push_ready)
                       & ~(~pwrite & mapped & ~sel_cfg & enabled & busy);
         pslverr_ff <= psel & ~pready_ff & ~mapped;
         prdata_ff  <= 32'h0000_0000;
         if (psel && !pready_ff && !pwrite) begin
            // (RULE_09) Busy status
            if (sel_cfg) begin
               prdata_ff <= {24'h00_0000, cfg_rd};
            end
            if (sel_d0) begin
               prdata_ff <= {24'h00_0000, data_ff[7:0]};
            end
            if (sel_d1) begin
               prdata_ff <= {24'h00_0000, data_ff[15:8]};
            end
            if (sel_d2) begin
               prdata_ff <= {24'h00_0000, data_ff[23:16]};
            end
            if (sel_d3) begin
               prdata_ff <= {24'h00_0000, data_ff[31:24]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= cca_pkg::cca_cfg_t'(5'(`CCA_CFG_RST >> `CCA_CFG_SEED_BIT));
         alg_ff <= cca_pkg::CCA_ALG_OFF;
      end else if (wr_done && sel_cfg) begin
         // (RULE_02) Width code
         cfg_ff.input_width_sel <= pwdata[`CCA_CFG_WIDTH_LO+1:`CCA_CFG_WIDTH_LO];
         cfg_ff.rev             <= pwdata[`CCA_CFG_REV_BIT];
         cfg_ff.carry_discard   <= pwdata[`CCA_CFG_NOC_BIT];
         cfg_ff.seed            <= pwdata[`CCA_CFG_SEED_BIT];
         // (RULE_08) Clear keeps algorithm
         if (!clear_cmd) begin
            alg_ff <= cca_pkg::cca_alg_t'(pwdata[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Entry capture
   // (RULE_11) Low byte starts work
   assign push_valid       = wr_done & sel_d0 & enabled;
   assign push_entry.width = cfg_ff.input_width_sel;
   assign push_entry.rev   = cfg_ff.rev;
   assign push_entry.seed  = cfg_ff.seed;
   assign push_entry.data  = {data_ff[31:8], pwdata[7:0]};

   cca_fifo #(
      .WIDTH (EW),
      .DEPTH (`CCA_FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_entry),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_entry)
   );

   assign pop_ready = (state_ff == cca_pkg::CCA_ST_IDLE) & enabled & ~clear_cmd;

   ////////////////////////////////////////////////////////////////////////////
   // Bit mirror across the selected width
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_mir
         assign mir32[g] = pop_entry.data[31-g];
         assign mir24[g] = (g < 24) ? pop_entry.data[(23-g+32)%32] : 1'b0;
         assign mir16[g] = (g < 16) ? pop_entry.data[(15-g+32)%32] : 1'b0;
         assign mir8[g]  = (g < 8)  ? pop_entry.data[(7-g+32)%32]  : 1'b0;
      end
   endgenerate

   // (RULE_03) Ordering select
   always_comb begin
      unique case (pop_entry.width)
         2'd0: engine_input_word = pop_entry.rev ? mir8  : {24'h00_0000, pop_entry.data[7:0]};
         2'd1: engine_input_word = pop_entry.rev ? mir16 : {16'h0000, pop_entry.data[15:0]};
         2'd2: engine_input_word = pop_entry.rev ? mir24 : {8'h00, pop_entry.data[23:0]};
         2'd3: engine_input_word = pop_entry.rev ? mir32 : pop_entry.data;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // One engine byte per cycle, low bit first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
                                            input logic wide, input logic [31:0] p);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = (wide ? r[31] : r[15]) ^ b[i];
         r  = wide ? {r[30:0], 1'b0} : {16'h0000, r[14:0], 1'b0};
         if (fb) begin
            r = r ^ p;
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [16:0] s;
      s         = 17'h0_0000;
      nxt_acc   = acc_ff;
      nxt_carry = carry_ff;
      // (RULE_07) Algorithm select
      unique case (alg_ff)
         cca_pkg::CCA_ALG_SUM8: begin
            // (RULE_05) Carry handling
            s         = {9'h000, acc_ff[7:0]} + {9'h000, ew_ff[7:0]}
                        + {16'h0000, carry_ff & ~cfg_ff.carry_discard};
            nxt_acc   = {24'h00_0000, s[7:0]};
            nxt_carry = s[8];
         end
         cca_pkg::CCA_ALG_SUM16: begin
            s         = {1'b0, acc_ff[15:0]} + (hi_ff ? {1'b0, ew_ff[7:0], 8'h00}
                                                      : {9'h000, ew_ff[7:0]})
                        + {16'h0000, carry_ff & ~cfg_ff.carry_discard};
            nxt_acc   = {16'h0000, s[15:0]};
            nxt_carry = s[16];
         end
         cca_pkg::CCA_ALG_CRCA:  nxt_acc = crc_byte(acc_ff, ew_ff[7:0], 1'b0, `CCA_POLY_A16);
         cca_pkg::CCA_ALG_CRCB:  nxt_acc = crc_byte(acc_ff, ew_ff[7:0], 1'b0, `CCA_POLY_B16);
         cca_pkg::CCA_ALG_CRC32: nxt_acc = crc_byte(acc_ff, ew_ff[7:0], 1'b1, `CCA_POLY_32);
         default: nxt_acc = acc_ff;
      endcase
   end

   always_comb begin
      unique case (alg_ff)
         cca_pkg::CCA_ALG_CRCA,
         cca_pkg::CCA_ALG_CRCB:  dflt_seed = `CCA_SEED_CRC16;
         cca_pkg::CCA_ALG_CRC32: dflt_seed = `CCA_SEED_CRC32;
         default:                dflt_seed = `CCA_SEED_SUM;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= cca_pkg::CCA_ST_IDLE;
         ew_ff    <= 32'h0000_0000;
         left_ff  <= 2'd0;
         hi_ff    <= 1'b0;
      end else begin
         unique case (state_ff)
            cca_pkg::CCA_ST_IDLE: begin
               // (RULE_06) Seed entries skip the engine
               if (pop_valid && pop_ready && !pop_entry.seed) begin
                  state_ff <= cca_pkg::CCA_ST_RUN;
                  ew_ff    <= engine_input_word;
                  // (RULE_01) One cycle per input byte
                  left_ff  <= pop_entry.width;
                  hi_ff    <= 1'b0;
               end
            end
            cca_pkg::CCA_ST_RUN: begin
               ew_ff <= {8'h00, ew_ff[31:8]};
               hi_ff <= ~hi_ff;
               if (left_ff == 2'd0 || clear_cmd) begin
                  state_ff <= cca_pkg::CCA_ST_IDLE;
               end else begin
                  left_ff <= left_ff - 2'd1;
               end
            end
         endcase
      end
   end

   // Clear has priority so a half-run byte cannot leak into the new seed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff   <= `CCA_SEED_SUM;
         carry_ff <= 1'b0;
      end else if (clear_cmd) begin
         // (RULE_08) Default seeds
         acc_ff   <= dflt_seed;
         carry_ff <= 1'b0;
      end else if (state_ff == cca_pkg::CCA_ST_IDLE && pop_valid && pop_ready
                   && pop_entry.seed) begin
         // (RULE_04) Seed keeps bit order
         acc_ff   <= pop_entry.data;
         carry_ff <= 1'b0;
      end else if (state_ff == cca_pkg::CCA_ST_RUN) begin
         acc_ff   <= nxt_acc;
         carry_ff <= nxt_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data registers; bus byte writes win over a result landing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ff <= `CCA_DATA_RST;
      end else if (clear_cmd) begin
         data_ff <= dflt_seed;
      end else begin
         // (RULE_15) Running result
         if (state_ff == cca_pkg::CCA_ST_RUN && left_ff == 2'd0) begin
            data_ff <= nxt_acc;
         end else if (state_ff == cca_pkg::CCA_ST_IDLE && pop_valid && pop_ready
                      && pop_entry.seed) begin
            data_ff <= pop_entry.data;
         end
         if (wr_done && sel_d0) begin
            data_ff[7:0] <= pwdata[7:0];
         end
         if (wr_done && sel_d1) begin
            data_ff[15:8] <= pwdata[7:0];
         end
         if (wr_done && sel_d2) begin
            data_ff[23:16] <= pwdata[7:0];
         end
         if (wr_done && sel_d3) begin
            data_ff[31:24] <= pwdata[7:0];
         end
      end
   end
endmodule

// [core/cca_params.svh]
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
// Register indexes; byte address is four times the index
`define CCA_IDX_CFG      18'h0_a078
`define CCA_IDX_DATA0    18'h0_a07c
`define CCA_IDX_DATA1    18'h0_a07d
`define CCA_IDX_DATA2    18'h0_a07e
`define CCA_IDX_DATA3    18'h0_a07f
// Config field positions
`define CCA_CFG_WIDTH_LO 6
`define CCA_CFG_REV_BIT  5
`define CCA_CFG_NOC_BIT  4
`define CCA_CFG_SEED_BIT 3
`define CCA_CFG_BUSY_BIT 0
// Reset values
`define CCA_CFG_RST      8'h00
`define CCA_DATA_RST     32'h0000_0000
// Default seeds
`define CCA_SEED_SUM     32'h0000_0000
`define CCA_SEED_CRC16   32'h0000_ffff
`define CCA_SEED_CRC32   32'hffff_ffff
// Polynomials without the top term
`define CCA_POLY_A16     32'h0000_8005
`define CCA_POLY_B16     32'h0000_1021
`define CCA_POLY_32      32'h04c1_1db7
// Input FIFO shape
`define CCA_FIFO_DEPTH   32
`endif

// [core/cca_pkg.sv]
package cca_pkg;
   typedef enum logic [2:0] {
      CCA_ALG_OFF   = 3'h0,
      CCA_ALG_SUM8  = 3'h1,
      CCA_ALG_SUM16 = 3'h2,
      CCA_ALG_CRCA  = 3'h3,
      CCA_ALG_CRCB  = 3'h4,
      CCA_ALG_CRC32 = 3'h5,
      CCA_ALG_RSVD  = 3'h6,
      CCA_ALG_CLEAR = 3'h7
   } cca_alg_t;
   typedef struct packed {
      logic [1:0]  width;
      logic        rev;
      logic        seed;
      logic [31:0] data;
   } cca_entry_t;
   typedef struct packed {
      logic [1:0] input_width_sel;
      logic       rev;
      logic       carry_discard;
      logic       seed;
   } cca_cfg_t;
   typedef enum logic [1:0] {
      CCA_ST_IDLE = 2'b01,
      CCA_ST_RUN  = 2'b10
   } cca_state_t;
endpackage

// [bench/cca_checker.sv]
`timescale 1ns/100ps
`include "cca_params.svh"
module cca_checker (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   localparam logic [19:0] A_CFG = {`CCA_IDX_CFG, 2'b00};
   localparam logic [19:0] A_D0  = {`CCA_IDX_DATA0, 2'b00};
   logic       mapped;
   logic       rd_cfg;
   logic       prompt;
   logic [4:0] cfg_ff;
   assign mapped = paddr == A_CFG || (paddr >= A_D0 && paddr <= A_D0 + 20'hc && paddr[1:0] == 2'b00);
   assign rd_cfg = pready && !pwrite && paddr == A_CFG;
   // Data reads may wait for a running result; everything else but a low-byte write is prompt
   assign prompt = pwrite ? paddr != A_D0 : (paddr == A_CFG || !mapped);
   // Shadow of the config fields; algorithm bits are write-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= 5'h0;
      end else if (psel && penable && pready && pwrite && paddr == A_CFG) begin
         cfg_ff <= pwdata[7:3];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside an access cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_ERR_UNMAPPED: assert property (psel && penable && pready |-> pslverr == !mapped)
      else $error("pslverr does not match address decode");
   AST_ERR_RDATA: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   AST_BYTE_WIDE: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   AST_PROMPT: assert property (psel && !penable && prompt |=> pready)
      else $error("access not answered in first access cycle");
   AST_ANSWER_BOUNDED: assert property (psel && !penable |-> ##[1:200] pready)
      else $error("transfer not answered within bound");
   AST_CFG_RSVD: assert property (rd_cfg |-> prdata[2:1] == 2'b00)
      else $error("config reserved bits not zero");
   AST_CFG_READBACK: assert property (rd_cfg |-> prdata[7:3] == cfg_ff)
      else $error("config fields not read back as written");
endmodule

bind cca_top cca_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// [bench/cca_host_model.sv]
`timescale 1ns/100ps
module cca_host_model (
   input  wire logic        pclk,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [19:0] paddr,
   output      logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 20'h0;
      pwdata = 32'h0;
   end
   // Plain transfers, no busy polling forced between entries
   task automatic xfer(input logic wr, input logic [19:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      // Idle edge so the next call never writes psel in the same step
      @(posedge pclk);
   endtask
endmodule

// [bench/tb_checksum_crc_accelerator.sv]
`timescale 1ns/100ps
`include "cca_params.svh"
module tb_checksum_crc_accelerator;
   localparam logic [19:0] A_CFG = {`CCA_IDX_CFG, 2'b00};
   localparam logic [19:0] A_D0  = {`CCA_IDX_DATA0, 2'b00};
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [19:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          num_errors = 0;
   int          compares = 0;
   int          seed = 48500;
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;
   cca_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   cca_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [19:0] a, output logic [31:0] r);
      logic e;
      host.xfer(1'b0, a, 32'h0, r, e);
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      host.xfer(1'b1, a, d, r, e);
   endtask
   // High bytes first, lowest byte last
   task automatic put(input int w, input logic [31:0] d);
      for (int i = w; i >= 0; i--) wr(A_D0 + 20'(4 * i), {24'h0, d[8*i +: 8]});
   endtask
   task automatic rdw(output logic [31:0] v);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) begin
         rd(A_D0 + 20'(4 * i), r);
         v[8*i +: 8] = r[7:0];
      end
   endtask
   // Bounded poll; a stuck busy shows up as a stalled data read later
   task automatic poll(output logic seen);
      logic [31:0] r;
      seen = 1'b0;
      r = 32'h1;
      for (int n = 0; n < 50 && r[0] !== 1'b0; n++) begin
         rd(A_CFG, r);
         if (r[0] === 1'b1) seen = 1'b1;
      end
   endtask
   function automatic logic [31:0] dflt(int m);
      return m < 3 ? `CCA_SEED_SUM : m == 5 ? `CCA_SEED_CRC32 : `CCA_SEED_CRC16;
   endfunction
   function automatic logic [31:0] crc(logic [31:0] a, int m, int w, logic rv, logic [31:0] d);
      logic [31:0] e;
      logic        fb;
      int          n;
      n = 8 * (w + 1);
      e = d;
      for (int i = 0; i < n; i++) e[i] = rv ? d[n-1-i] : d[i];
      for (int i = 0; i < n; i++) begin
         fb = e[i] ^ (m == 5 ? a[31] : a[15]);
         a = a << 1;
         if (fb) a = a ^ (m == 5 ? `CCA_POLY_32 : m == 3 ? `CCA_POLY_A16 : `CCA_POLY_B16);
      end
      return a;
   endfunction
   initial begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      end_sim();
   end
   initial begin
      logic [31:0] v;
      logic [31:0] d;
      logic [31:0] acc;
      logic [31:0] mk;
      logic [16:0] s;
      logic [7:0]  cf;
      logic        sn;
      logic        c;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_CFG, v);
      chk("cfg reset", 32'h0, v);
      rdw(v);
      chk("data reset", `CCA_DATA_RST, v);
      host.xfer(1'b0, A_CFG + 20'h4, 32'h0, v, sn);
      chk("unmapped err", 32'h1, {31'h0, sn});
      for (int m = 0; m < 8; m += 6) begin
         wr(A_CFG, 32'(m) | 32'hc0);
         d = $random(seed);
         put(3, d);
         rdw(v);
         chk("dropped entry", d, v);
      end
      for (int m = 1; m < 6; m++) begin
         wr(A_CFG, 32'(m));
         wr(A_CFG, 32'h7);
         rdw(v);
         chk("clear seed", dflt(m), v);
      end
      for (int m = 3; m < 6; m++)
         for (int w = 0; w < 4; w++)
            for (int rv = 0; rv < 2; rv++) begin
               cf = {w[1:0], rv[0], 2'b00, m[2:0]};
               mk = m == 5 ? 32'hffff_ffff : 32'hffff;
               wr(A_CFG, {24'h0, cf});
               wr(A_CFG, {24'h0, cf | 8'h07});
               acc = dflt(m);
               if (rv == 1) begin
                  wr(A_CFG, {24'h0, cf | 8'h08});
                  d = $random(seed);
                  put(3, d);
                  acc = d;
                  wr(A_CFG, {24'h0, cf});
                  poll(sn);
                  rdw(v);
                  chk("seed word", d, v);
               end
               repeat (3) begin
                  d = $random(seed);
                  put(w, d);
                  acc = crc(acc, m, w, rv[0], d);
                  if (w > 1) poll(sn);
                  if (w == 3) chk("busy seen", 32'h1, {31'h0, sn});
                  rdw(v);
                  chk("crc result", acc & mk, v & mk);
               end
               rd(A_CFG, v);
               chk("cfg readback", {24'h0, cf[7:3], 3'h0}, v);
            end
      // Byte sum on 8-bit entries, then 16-bit sum on 32-bit entries, carry kept or dropped
      for (int nc = 0; nc < 4; nc++) begin
         wr(A_CFG, (nc > 1 ? 32'hc2 : 32'h01) | (nc % 2 == 1 ? 32'h10 : 32'h00));
         wr(A_CFG, (nc > 1 ? 32'hc7 : 32'h07) | (nc % 2 == 1 ? 32'h10 : 32'h00));
         acc = 32'h0;
         c = 1'b0;
         for (int k = 0; k < 6; k++) begin
            d = k < 3 ? 32'hffff_ffff : $random(seed);
            put(nc > 1 ? 3 : 0, d);
            for (int i = 0; i <= (nc > 1 ? 3 : 0); i++) begin
               s = {1'b0, acc[15:0]} + (i % 2 == 1 ? {1'b0, d[8*i +: 8], 8'h00}
                                                   : {9'h000, d[8*i +: 8]})
                   + {16'h0000, nc % 2 == 0 ? c : 1'b0};
               acc = nc > 1 ? {16'h0000, s[15:0]} : {24'h00_0000, s[7:0]};
               c = nc > 1 ? s[16] : s[8];
            end
            rd(A_D0, v);
            chk("checksum low", {24'h0, acc[7:0]}, v);
            rdw(v);
            chk("checksum", acc, v);
         end
      end
      wr(A_CFG, 32'h5);
      wr(A_CFG, 32'h7);
      acc = `CCA_SEED_CRC32;
      repeat (40) begin
         d = $random(seed);
         put(0, d);
         acc = crc(acc, 5, 0, 1'b0, d);
      end
      poll(sn);
      rdw(v);
      chk("burst result", acc, v);
      wr(A_D0 + 20'h4, 32'h5a);
      rdw(v);
      chk("store only", {acc[31:16], 8'h5a, acc[7:0]}, v);
      end_sim();
   end
endmodule
